//--- design/motion_freefall_autosleep_logic.sv
// Freefall/motion detector with debounce, event source flags and auto-sleep timing.
// Assumes one AHB-Lite master, signed 10-bit samples at 8 g scale with a sample strobe per output sample.
//
// Functional notes
// RL1: Event-active sets when the chosen axis combination is true.
// RL2: Motion condition is true when any enabled axis magnitude exceeds threshold.
// RL3: Freefall condition is true only when all axis magnitudes are below threshold; the code compares enabled axes only and ignores disabled ones.
// RL4: Source register: bit7 event, bit6 zero, then Z, Y, X flag pairs.
// RL5: Axis flag and polarity read zero while that axis is disabled.
// RL6: Polarity reads 0 for positive, 1 for negative acceleration.
// RL7: Threshold is unsigned seven bits, 0.063 g per count.
// RL8: Comparison covers the full 8 g range regardless of output scale.
// RL9: Clear mode resets the debounce counter on any false sample.
// RL10: Decrement mode counts down by one per false sample, stopping at zero.
// RL11: Event flag sets when the debounce counter equals the programmed count.
// RL12: Debounce counter saturates at the programmed count.
// RL13: Each debounce step is one sample period of the current rate and mode.
// RL14: With auto-sleep on, switch to sleep rate after programmed inactivity.
// RL15: Inactivity step is 320 ms, or 640 ms at the slowest rate.
// RL16: Orientation and motion events restart inactivity and may wake.
// RL17: Detection runs in sleep; only selected wake sources return to wake; the code also returns to wake when auto-sleep is turned off.
// RL18: Without auto-sleep, only standby and wake modes are used.
// RL19: Sleep interrupt fires on every wake-to-sleep and sleep-to-wake change.
// RL20: Motion interrupt is event-active gated by enable and routed by config.
// RL21: Combine select 0 picks freefall AND, 1 picks motion OR.
// RL22: Latched mode freezes flags; source read clears them and the counter.
// RL23: Unlatched motion with clear mode drops event-active as condition ends.
// RL24: Debounce counter increments by one per true sample up to saturation.
`timescale 1ns/1ps
`default_nettype none
module motion_freefall_autosleep_logic #(
    parameter int INACT_STEP = motion_pkg::INACT_STEP_CYC,
    parameter int INACT_STEP_SLOW = motion_pkg::INACT_STEP_SLOW_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_sample_strobe,
    input wire logic [29:0] i_sample_xyz,
    input wire logic i_orientation_event,
    output logic o_motion_int1,
    output logic o_motion_int2,
    output logic o_sleep_int,
    output logic o_sleep_rate_on,
    output motion_pkg::power_mode_t o_power_mode
);
    import motion_pkg::*;

    // =====================================================================
    // Register file over AHB-Lite
    logic [7:0] config_reg, threshold_reg, debounce_reg, sleep_count_reg;
    logic [7:0] system_reg, power_reg, wake_source_reg, int_enable_reg, int_route_reg;
    logic [7:0] next_config_reg, next_threshold_reg, next_debounce_reg, next_sleep_count_reg;
    logic [7:0] next_system_reg, next_power_reg, next_wake_source_reg, next_int_enable_reg, next_int_route_reg;
    logic dp_write, next_dp_write, dp_read, next_dp_read;
    logic [7:0] dp_index, next_dp_index;
    logic [31:0] next_hrdata;
    logic [7:0] source_view;
    logic source_read;
    power_mode_t mode, next_mode;

    always_comb
    begin
        next_dp_write = 1'b0;
        next_dp_read = 1'b0;
        next_dp_index = dp_index;
        if (i_hready && i_hsel && i_htrans[1])
        begin
            next_dp_write = i_hwrite;
            next_dp_read = !i_hwrite;
            next_dp_index = i_haddr[9:2];
        end
        next_config_reg = config_reg;
        next_threshold_reg = threshold_reg;
        next_debounce_reg = debounce_reg;
        next_sleep_count_reg = sleep_count_reg;
        next_system_reg = system_reg;
        next_power_reg = power_reg;
        next_wake_source_reg = wake_source_reg;
        next_int_enable_reg = int_enable_reg;
        next_int_route_reg = int_route_reg;
        if (dp_write)
        begin
            unique case (dp_index)
                IDX_CONFIG: next_config_reg = {i_hwdata[7:3], 3'h0};
                IDX_THRESHOLD: next_threshold_reg = i_hwdata[7:0];
                IDX_DEBOUNCE: next_debounce_reg = i_hwdata[7:0];
                IDX_SLEEP_COUNT: next_sleep_count_reg = i_hwdata[7:0];
                IDX_SYSTEM: next_system_reg = i_hwdata[7:0];
                IDX_POWER: next_power_reg = i_hwdata[7:0];
                IDX_WAKE_SOURCE: next_wake_source_reg = i_hwdata[7:0];
                IDX_INT_ENABLE: next_int_enable_reg = i_hwdata[7:0];
                IDX_INT_ROUTE: next_int_route_reg = i_hwdata[7:0];
                default: ;
            endcase
        end
        next_hrdata = 32'h0;
        if (next_dp_read)
        begin
            unique case (next_dp_index)
                IDX_SOURCE: next_hrdata = {24'h0, source_view};
                IDX_CONFIG: next_hrdata = {24'h0, config_reg};
                IDX_THRESHOLD: next_hrdata = {24'h0, threshold_reg};
                IDX_DEBOUNCE: next_hrdata = {24'h0, debounce_reg};
                IDX_SLEEP_COUNT: next_hrdata = {24'h0, sleep_count_reg};
                IDX_SYSTEM: next_hrdata = {24'h0, system_reg};
                IDX_POWER: next_hrdata = {24'h0, power_reg};
                IDX_WAKE_SOURCE: next_hrdata = {24'h0, wake_source_reg};
                IDX_INT_ENABLE: next_hrdata = {24'h0, int_enable_reg};
                IDX_INT_ROUTE: next_hrdata = {24'h0, int_route_reg};
                IDX_MODE: next_hrdata = {30'h0, mode};
                default: next_hrdata = 32'h0;
            endcase
        end
    end

    // A source read is recognised in its address phase so the clear lines up with the data returned.
    assign source_read = i_hready && i_hsel && i_htrans[1] && !i_hwrite && (i_haddr[9:2] == IDX_SOURCE);

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            config_reg <= RST_REG;
            threshold_reg <= RST_REG;
            debounce_reg <= RST_REG;
            sleep_count_reg <= RST_REG;
            system_reg <= RST_REG;
            power_reg <= RST_REG;
            wake_source_reg <= RST_REG;
            int_enable_reg <= RST_REG;
            int_route_reg <= RST_REG;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= 8'h00;
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else if (i_clk_en)
        begin
            config_reg <= next_config_reg;
            threshold_reg <= next_threshold_reg;
            debounce_reg <= next_debounce_reg;
            sleep_count_reg <= next_sleep_count_reg;
            system_reg <= next_system_reg;
            power_reg <= next_power_reg;
            wake_source_reg <= next_wake_source_reg;
            int_enable_reg <= next_int_enable_reg;
            int_route_reg <= next_int_route_reg;
            dp_write <= next_dp_write;
            dp_read <= next_dp_read;
            dp_index <= next_dp_index;
            o_hrdata <= next_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // =====================================================================
    // Per-axis compare and combination
    logic flag_latch_on, axis_combine_select, debounce_clear_mode;
    logic [2:0] axis_detect_on, axis_high, axis_low, axis_negative;
    logic [6:0] threshold_value;
    logic condition;
    assign flag_latch_on = config_reg[CFG_LATCH_BIT];
    assign axis_combine_select = config_reg[CFG_COMBINE_BIT];
    assign axis_detect_on = {config_reg[CFG_Z_BIT], config_reg[CFG_Y_BIT], config_reg[CFG_X_BIT]};
    assign debounce_clear_mode = threshold_reg[THS_MODE_BIT];
    assign threshold_value = threshold_reg[6:0]; // RL7

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++)
        begin : g_axis
            logic [9:0] raw, mag;
            assign raw = i_sample_xyz[ax*10 +: 10];
            assign axis_negative[ax] = raw[9]; // RL6
            assign mag = raw[9] ? 10'(-raw) : raw;
            // Samples are taken at the 8 g scale, so one threshold count is four sample counts.
            assign axis_high[ax] = mag > {1'b0, threshold_value, 2'h0}; // RL2 RL8
            assign axis_low[ax] = mag < {1'b0, threshold_value, 2'h0}; // RL3
        end
    endgenerate

    // An empty axis selection never fires in either combination.
    assign condition = axis_combine_select
        ? |(axis_high & axis_detect_on) // RL21
        : (axis_detect_on != 3'h0) && ((axis_low | ~axis_detect_on) == 3'h7); // RL21

    // =====================================================================
    // Debounce counter and event source flags
    logic [7:0] debounce_cnt, next_debounce_cnt;
    logic event_active, next_event_active;
    logic [2:0] exceed_flag, next_exceed_flag, polarity_flag, next_polarity_flag;
    logic frozen;
    logic motion_event;

    assign frozen = flag_latch_on && event_active;

    always_comb
    begin
        next_debounce_cnt = debounce_cnt;
        next_event_active = event_active;
        next_exceed_flag = exceed_flag;
        next_polarity_flag = polarity_flag;
        if (i_sample_strobe && system_reg[SYS_ACTIVE_BIT]) // RL13
        begin
            if (condition)
            begin
                if (debounce_cnt < debounce_reg) // RL12
                    next_debounce_cnt = debounce_cnt + 8'h01; // RL24
            end
            else if (debounce_clear_mode)
                next_debounce_cnt = 8'h00; // RL9
            else if (debounce_cnt != 8'h00)
                next_debounce_cnt = debounce_cnt - 8'h01; // RL10
            if (!frozen)
            begin
                next_exceed_flag = axis_high & axis_detect_on;
                next_polarity_flag = axis_negative & axis_high & axis_detect_on;
                if (condition && next_debounce_cnt == debounce_reg)
                    next_event_active = 1'b1; // RL1 RL11
                else if (!flag_latch_on && next_debounce_cnt == 8'h00)
                    next_event_active = 1'b0; // RL23
            end
        end
        // The clear loses to an event set in the same cycle: the new set, the count and the flags are all kept.
        if (source_read && flag_latch_on && !next_event_active)
        begin
            next_exceed_flag = 3'h0;
            next_polarity_flag = 3'h0;
        end
        if (source_read && flag_latch_on && event_active && next_event_active == event_active) // RL22
        begin
            next_event_active = 1'b0;
            next_debounce_cnt = 8'h00;
            next_exceed_flag = 3'h0;
            next_polarity_flag = 3'h0;
        end
    end

    assign source_view = {event_active, 1'b0, exceed_flag[2] & axis_detect_on[2], // RL4 RL5
        polarity_flag[2] & axis_detect_on[2], exceed_flag[1] & axis_detect_on[1],
        polarity_flag[1] & axis_detect_on[1], exceed_flag[0] & axis_detect_on[0],
        polarity_flag[0] & axis_detect_on[0]};
    assign motion_event = next_event_active && !event_active;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            debounce_cnt <= 8'h00;
            event_active <= 1'b0;
            exceed_flag <= 3'h0;
            polarity_flag <= 3'h0;
        end
        else if (i_clk_en)
        begin
            debounce_cnt <= next_debounce_cnt;
            event_active <= next_event_active;
            exceed_flag <= next_exceed_flag;
            polarity_flag <= next_polarity_flag;
        end
    end

    // =====================================================================
    // Auto-sleep timing and power mode
    logic [31:0] step_cnt, next_step_cnt;
    logic [7:0] inact_cnt, next_inact_cnt;
    logic keep_awake, wake_request, step_done, autosleep_on;
    logic next_motion_int1, next_motion_int2, next_sleep_int;

    assign autosleep_on = power_reg[PWR_SLEEP_ON_BIT];
    // RL16: orientation and motion events restart the timer; sleep and data-ready events are not inputs.
    assign keep_awake = i_orientation_event || motion_event; // RL16
    assign wake_request = (i_orientation_event && wake_source_reg[WAKE_ORIENT_BIT]) // RL17
        || (motion_event && wake_source_reg[WAKE_MOTION_BIT]);
    // RL15: the slowest wake rate doubles the step.
    assign step_done = (system_reg[5:3] == RATE_SLOWEST) ? (step_cnt >= 32'(INACT_STEP_SLOW - 1)) // RL15
        : (step_cnt >= 32'(INACT_STEP - 1));

    always_comb
    begin
        next_mode = mode;
        // Standby drops any partial inactivity count so every fresh wake starts timing from zero.
        next_step_cnt = (mode == MODE_STANDBY) ? 32'h0 : step_cnt;
        next_inact_cnt = (mode == MODE_STANDBY) ? 8'h00 : inact_cnt;
        unique case (mode)
            MODE_STANDBY:
                if (system_reg[SYS_ACTIVE_BIT])
                    next_mode = MODE_WAKE;
            MODE_WAKE:
            begin
                if (!system_reg[SYS_ACTIVE_BIT])
                    next_mode = MODE_STANDBY;
                else if (keep_awake || !autosleep_on) // RL18
                begin
                    next_step_cnt = 32'h0;
                    next_inact_cnt = 8'h00;
                end
                else if (inact_cnt >= sleep_count_reg)
                    next_mode = MODE_SLEEP; // RL14
                else if (step_done)
                begin
                    next_step_cnt = 32'h0;
                    next_inact_cnt = inact_cnt + 8'h01;
                end
                else
                    next_step_cnt = step_cnt + 32'h1;
            end
            MODE_SLEEP:
                if (!system_reg[SYS_ACTIVE_BIT])
                    next_mode = MODE_STANDBY;
                else if (wake_request || !autosleep_on) // RL17
                begin
                    next_mode = MODE_WAKE;
                    next_step_cnt = 32'h0;
                    next_inact_cnt = 8'h00;
                end
        endcase
        next_sleep_int = int_enable_reg[INT_SLEEP_BIT] && (mode != next_mode) // RL19
            && (mode != MODE_STANDBY) && (next_mode != MODE_STANDBY);
        next_motion_int1 = event_active && int_enable_reg[INT_MOTION_BIT] && int_route_reg[INT_MOTION_BIT]; // RL20
        next_motion_int2 = event_active && int_enable_reg[INT_MOTION_BIT] && !int_route_reg[INT_MOTION_BIT]; // RL20
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode <= MODE_STANDBY;
            step_cnt <= 32'h0;
            inact_cnt <= 8'h00;
            o_sleep_int <= 1'b0;
            o_motion_int1 <= 1'b0;
            o_motion_int2 <= 1'b0;
            o_sleep_rate_on <= 1'b0;
            o_power_mode <= MODE_STANDBY;
        end
        else if (i_clk_en)
        begin
            mode <= next_mode;
            step_cnt <= next_step_cnt;
            inact_cnt <= next_inact_cnt;
            o_sleep_int <= next_sleep_int;
            o_motion_int1 <= next_motion_int1;
            o_motion_int2 <= next_motion_int2;
            o_sleep_rate_on <= next_mode == MODE_SLEEP;
            o_power_mode <= next_mode;
        end
    end

    // =====================================================================
    // Checks
    bit_six_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) source_view[6] == 1'b0) // RL4
        else $error("source bit 6 not zero");
    axis_mask_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !axis_detect_on[0] |-> source_view[1:0] == 2'h0) // RL5
        else $error("disabled x flags not zero");
    counter_sat_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $changed(debounce_cnt) && !$changed(debounce_reg) |-> debounce_cnt <= debounce_reg) // RL12
        else $error("debounce counter passed limit");
    clear_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_clk_en && i_sample_strobe && system_reg[SYS_ACTIVE_BIT] && !condition && debounce_clear_mode
        |=> debounce_cnt == 8'h00) // RL9
        else $error("clear mode did not clear");
    dec_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_clk_en && i_sample_strobe && system_reg[SYS_ACTIVE_BIT] && !condition && !debounce_clear_mode
        && !source_read && debounce_cnt != 8'h00 |=> debounce_cnt == $past(debounce_cnt) - 8'h01) // RL10
        else $error("decrement mode step wrong");
    latch_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        flag_latch_on && event_active && !source_read && !$changed(config_reg) |=> event_active) // RL22
        else $error("latched event dropped");
    no_sleep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !autosleep_on && mode != MODE_SLEEP |=> mode != MODE_SLEEP) // RL18
        else $error("sleep entered without auto-sleep");
    sleep_int_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_clk_en && int_enable_reg[INT_SLEEP_BIT] && mode == MODE_WAKE && next_mode == MODE_SLEEP
        |=> o_sleep_int && o_power_mode == MODE_SLEEP) // RL19
        else $error("sleep transition did not interrupt");
    motion_int_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_clk_en && event_active && int_enable_reg[INT_MOTION_BIT] |=> o_motion_int1 || o_motion_int2) // RL20
        else $error("motion interrupt missing");
endmodule
`default_nettype wire

//--- design/motion_pkg.sv
// Constants shared by the freefall/motion and auto-sleep logic.
// Assumes word-aligned AHB-Lite register slots, printed offsets used as indices.
package motion_pkg;
    // =====================================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_SOURCE = 8'h16;
    localparam logic [7:0] IDX_THRESHOLD = 8'h17;
    localparam logic [7:0] IDX_DEBOUNCE = 8'h18;
    localparam logic [7:0] IDX_SLEEP_COUNT = 8'h29;
    localparam logic [7:0] IDX_CONFIG = 8'h15;
    localparam logic [7:0] IDX_SYSTEM = 8'h2A;
    localparam logic [7:0] IDX_POWER = 8'h2B;
    localparam logic [7:0] IDX_WAKE_SOURCE = 8'h2C;
    localparam logic [7:0] IDX_INT_ENABLE = 8'h2D;
    localparam logic [7:0] IDX_INT_ROUTE = 8'h2E;
    localparam logic [7:0] IDX_MODE = 8'h0B;
    // =====================================================================
    // Field positions
    localparam int SRC_EVENT_BIT = 7;
    localparam int THS_MODE_BIT = 7;
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_COMBINE_BIT = 6;
    localparam int CFG_Z_BIT = 5;
    localparam int CFG_Y_BIT = 4;
    localparam int CFG_X_BIT = 3;
    localparam int SYS_ACTIVE_BIT = 0;
    localparam int PWR_SLEEP_ON_BIT = 2;
    localparam int WAKE_MOTION_BIT = 3;
    localparam int WAKE_ORIENT_BIT = 5;
    localparam int INT_SLEEP_BIT = 7;
    localparam int INT_MOTION_BIT = 2;
    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // =====================================================================
    // Timing
    localparam int CLK_HZ = 40000000;
    localparam int INACT_STEP_MS = 320;
    localparam int INACT_STEP_SLOW_MS = 640;
    localparam int INACT_STEP_CYC = INACT_STEP_MS * (CLK_HZ / 1000);
    localparam int INACT_STEP_SLOW_CYC = INACT_STEP_SLOW_MS * (CLK_HZ / 1000);
    localparam logic [2:0] RATE_SLOWEST = 3'h7;
    // =====================================================================
    // Power modes and oversampling schemes
    typedef enum logic [1:0] {MODE_STANDBY, MODE_WAKE, MODE_SLEEP} power_mode_t;
    localparam logic [1:0] OS_HIGH_RES = 2'h2;
endpackage

//--- verif/ahb_host_model.sv
// AHB-Lite single master standing in for host software.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output var logic o_hsel,
    output var logic [31:0] o_haddr,
    output var logic [1:0] o_htrans,
    output var logic o_hwrite,
    output var logic [2:0] o_hsize,
    output var logic [31:0] o_hwdata
);
    initial
    begin
        {o_hsel, o_haddr, o_htrans, o_hwrite, o_hsize, o_hwdata} = '0;
    end
    // Called just after a rising edge; holds each phase until hready is seen high.
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        o_hsel <= 1'b1;
        o_haddr <= {22'h000000, idx, 2'b00};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        @(posedge i_clk);
        while (i_hready !== 1'b1) @(posedge i_clk);
        o_htrans <= 2'h0;
        o_hwdata <= wd;
        @(posedge i_clk);
        while (i_hready !== 1'b1) @(posedge i_clk);
        rd = i_hrdata;
    endtask
endmodule
`default_nettype wire

//--- verif/motion_freefall_autosleep_logic_tb_top.sv
// Self-checking bench for the freefall/motion and auto-sleep block.
// Assumes short inactivity steps set through the parameters.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module motion_freefall_autosleep_logic_tb_top;
    import motion_pkg::*;
    logic clk = 0, rst_n = 0, stb = 0, orient = 0, ce = 1, hsel, hwrite, hready, hresp, int1, int2, sint, srate;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [29:0] xyz = '0;
    power_mode_t mode;
    int n_errors = 0, tests_run = 0, cyc = 0, n_sint = 0;
    ahb_host_model host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    motion_freefall_autosleep_logic #(.INACT_STEP(8), .INACT_STEP_SLOW(16)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_clk_en(ce), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_sample_strobe(stb), .i_sample_xyz(xyz), .i_orientation_event(orient), .o_motion_int1(int1),
        .o_motion_int2(int2), .o_sleep_int(sint), .o_sleep_rate_on(srate), .o_power_mode(mode));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (sint === 1'b1) n_sint++;
        if (cyc == 20000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.xfer(idx, 1'b1, {24'h000000, d}, r);
    endtask
    task automatic rd(input logic [7:0] idx);
        host.xfer(idx, 1'b0, 32'h00000000, r);
    endtask
    // One sample strobe, then two cycles so flags and interrupts have landed.
    task automatic smp(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
        stb <= 1'b1;
        xyz <= {z, y, x};
        @(posedge clk);
        stb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_mode(input power_mode_t m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) @(posedge clk);
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_regs();
        rd(IDX_DEBOUNCE);
        `CHK(r[7:0], 8'h00)
        rd(IDX_SLEEP_COUNT);
        `CHK(r[7:0], 8'h00)
        rd(8'h3F);
        `CHK(r, 32'h00000000)
        `CHK(hresp, 1'b0)
        $display("test regs done");
    endtask
    // Boundary threshold 127 with samples at full 8 g; Y is over but disabled.
    task automatic t_motion_clear();
        wr(IDX_CONFIG, 8'h48);
        wr(IDX_THRESHOLD, 8'hFF);
        wr(IDX_DEBOUNCE, 8'h02);
        wr(IDX_INT_ENABLE, 8'h04);
        wr(IDX_INT_ROUTE, 8'h04);
        wr(IDX_SYSTEM, 8'h01);
        smp(10'h200, 10'h200, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b0)
        smp(10'h200, 10'h200, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7:0], 8'h83)
        `CHK({int1, int2}, 2'b10)
        smp(10'h1FC, 10'h000, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7:0], 8'h00)
        `CHK(int1, 1'b0)
        `CHK(mode, MODE_WAKE)
        $display("test motion clear done");
    endtask
    // Second pin routing, one true sample past saturation, and a strobe lost while the clock enable is low.
    task automatic t_motion_decr();
        wr(IDX_THRESHOLD, 8'h04);
        wr(IDX_INT_ROUTE, 8'h00);
        repeat (3) smp(10'h028, 10'h000, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7:0], 8'h82)
        `CHK({int1, int2}, 2'b01)
        smp(10'h000, 10'h000, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b1)
        ce <= 1'b0;
        smp(10'h000, 10'h000, 10'h000);
        ce <= 1'b1;
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b1)
        smp(10'h000, 10'h000, 10'h000);
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b0)
        $display("test motion decrement done");
    endtask
    task automatic t_freefall_latch();
        wr(IDX_CONFIG, 8'hB8);
        wr(IDX_THRESHOLD, 8'h84);
        wr(IDX_DEBOUNCE, 8'h01);
        smp(10'h000, 10'h000, 10'h000);
        smp(10'h000, 10'h000, 10'h3D8);
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b1)
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b0)
        smp(10'h000, 10'h000, 10'h3D8);
        rd(IDX_SOURCE);
        `CHK(r[7], 1'b0)
        $display("test freefall latched done");
    endtask
    task automatic t_autosleep();
        wr(IDX_SYSTEM, 8'h00);
        wr(IDX_SLEEP_COUNT, 8'h02);
        wr(IDX_WAKE_SOURCE, 8'h20);
        wr(IDX_INT_ENABLE, 8'h80);
        wr(IDX_POWER, 8'h04);
        n_sint = 0;
        wr(IDX_SYSTEM, 8'h01);
        repeat (8) @(posedge clk);
        `CHK(mode, MODE_WAKE)
        wait_mode(MODE_SLEEP, 100);
        `CHK(mode, MODE_SLEEP)
        @(posedge clk);
        `CHK(srate, 1'b1)
        orient <= 1'b1;
        @(posedge clk);
        orient <= 1'b0;
        wait_mode(MODE_WAKE, 10);
        `CHK(mode, MODE_WAKE)
        `CHK(srate, 1'b0)
        repeat (2) @(posedge clk);
        `CHK(n_sint, 2)
        // At the slowest wake rate two inactivity steps take 32 cycles; the normal step would sleep by 18.
        wr(IDX_SYSTEM, 8'h00);
        wr(IDX_SYSTEM, 8'h39);
        repeat (24) @(posedge clk);
        `CHK(mode, MODE_WAKE)
        wait_mode(MODE_SLEEP, 40);
        `CHK(mode, MODE_SLEEP)
        $display("test autosleep done");
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_motion_clear();
        t_motion_decr();
        t_freefall_latch();
        t_autosleep();
        conclude();
    end
endmodule
`default_nettype wire
